// ===== hdl/odpd_top.sv
// termination control for dll-off and power-down with axi4-lite registers
`timescale 1ns/10ps
module odpd_top (
  input  wire logic        CLOCK_I,
  input  wire logic        RST_I,
  input  wire logic        CE_I,
  input  wire logic        ODT_I,
  input  wire logic        CKE_I,
  output logic      [2:0]  RTT_CODE_O,
  output logic             RTT_NOM_ON_O,
  output logic             POWER_DOWN_O,
  input  wire logic [11:0] AWADDR_I,
  input  wire logic        AWVALID_I,
  output logic             AWREADY_O,
  input  wire logic [31:0] WDATA_I,
  input  wire logic [3:0]  WSTRB_I,
  input  wire logic        WVALID_I,
  output logic             WREADY_O,
  output logic      [1:0]  BRESP_O,
  output logic             BVALID_O,
  input  wire logic        BREADY_I,
  input  wire logic [11:0] ARADDR_I,
  input  wire logic        ARVALID_I,
  output logic             ARREADY_O,
  output logic      [31:0] RDATA_O,
  output logic      [1:0]  RRESP_O,
  output logic             RVALID_O,
  input  wire logic        RREADY_I
);
  // ---------------------------------------------------------------------------
  // pin sampling
  // ---------------------------------------------------------------------------
  logic [1:0] pins_s;
  logic       odt_s;
  logic       cke_s;

  // cke travels inverted so the synchroniser's reset value reads as powered up,
  // otherwise a false power-down entry would follow every reset
  odpd_sync2 #(
    .WIDTH (2)
  ) u_sync (
    .clk_i (CLOCK_I),
    .rst_i (RST_I),
    .ce_i  (CE_I),
    .d_i   ({ODT_I, !CKE_I}),
    .q_o   (pins_s)
  );
  assign odt_s = pins_s[1];
  assign cke_s = !pins_s[0];

  // ---------------------------------------------------------------------------
  // mode fields
  // ---------------------------------------------------------------------------
  logic       dll_en_q,   dll_en_d;
  logic [2:0] rtt_nom_q,  rtt_nom_d;
  logic [2:0] rtt_wr_q,   rtt_wr_d;
  logic       buf_dis_q,  buf_dis_d;
  logic [2:0] rtt_park_q, rtt_park_d;
  logic [4:0] wl_q,       wl_d;

  // ---------------------------------------------------------------------------
  // termination core
  // ---------------------------------------------------------------------------
  localparam int PIPE_W = odpd_pkg::PIPE_DEPTH;
  logic                  async_mode;
  logic                  pd_block;
  logic                  dyn_odt_bad;
  logic [PIPE_W-1:0]     odt_pipe_q, odt_pipe_d;
  logic                  sync_nom;
  logic                  async_nom;
  logic                  async_busy;
  logic                  nom_apply;
  logic [2:0]            code_q,    code_d;
  logic                  nom_on_q,  nom_on_d;
  logic                  pd_q,      pd_d;

  assign async_mode  = !dll_en_q;
  assign pd_block    = !cke_s && buf_dis_q;
  // write termination is never applied here; a nonzero field with dll off is flagged
  assign dyn_odt_bad = async_mode && (rtt_wr_q != 3'h0);

  odpd_turn_timer u_timer (
    .clk_i  (CLOCK_I),
    .rst_i  (RST_I),
    .ce_i   (CE_I),
    .req_i  (async_mode && odt_s && !pd_block),
    .nom_o  (async_nom),
    .busy_o (async_busy)
  );

  // synchronous path delays the sample by write latency minus one
  assign sync_nom = odt_pipe_q[odpd_pkg::lat_index(wl_q)];

  always_comb begin
    odt_pipe_d = {odt_pipe_q[PIPE_W-2:0], odt_s};
    // flushing drops every sample taken in the window before entry, so park wins
    if (pd_block) begin
      odt_pipe_d = '0;
    end
    nom_apply = (async_mode ? async_nom : sync_nom) && !pd_block;
    code_d    = nom_apply ? rtt_nom_q : rtt_park_q;
    nom_on_d  = nom_apply;
    pd_d      = !cke_s;
  end

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      odt_pipe_q <= '0;
      code_q     <= odpd_pkg::RTT_RST;
      nom_on_q   <= 1'b0;
      pd_q       <= 1'b0;
    end else if (CE_I) begin
      odt_pipe_q <= odt_pipe_d;
      code_q     <= code_d;
      nom_on_q   <= nom_on_d;
      pd_q       <= pd_d;
    end
  end

  assign RTT_CODE_O   = code_q;
  assign RTT_NOM_ON_O = nom_on_q;
  assign POWER_DOWN_O = pd_q;

  // ---------------------------------------------------------------------------
  // register words
  // ---------------------------------------------------------------------------
  logic [31:0] mr1_w, mr2_w, mr5_w, tim_w, stat_w;

  always_comb begin
    mr1_w = 32'h0;
    mr2_w = 32'h0;
    mr5_w = 32'h0;
    tim_w = 32'h0;
    mr1_w[odpd_pkg::DLL_EN_BIT]       = dll_en_q;
    mr1_w[odpd_pkg::NOM_LSB +: 3]     = rtt_nom_q;
    mr2_w[odpd_pkg::WR_LSB +: 3]      = rtt_wr_q;
    mr5_w[odpd_pkg::BUF_DIS_BIT]      = buf_dis_q;
    mr5_w[odpd_pkg::PARK_LSB +: 3]    = rtt_park_q;
    tim_w[odpd_pkg::WL_LSB +: 5]      = wl_q;
    stat_w = {23'h0, async_busy, odt_s, dyn_odt_bad, async_mode, pd_q, nom_on_q, code_q};
  end

  function automatic logic [32:0] reg_pick(input logic [11:0] a,
                                           input logic [31:0] m1, m2, m5, tm, st);
    case (a)
      odpd_pkg::ADDR_MR1:    reg_pick = {1'b1, m1};
      odpd_pkg::ADDR_MR2:    reg_pick = {1'b1, m2};
      odpd_pkg::ADDR_MR5:    reg_pick = {1'b1, m5};
      odpd_pkg::ADDR_TIMING: reg_pick = {1'b1, tm};
      odpd_pkg::ADDR_STATUS: reg_pick = {1'b1, st};
      default:               reg_pick = {1'b0, 32'h0};
    endcase
  endfunction

  // ---------------------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------------------
  logic        awready_q, awready_d, aw_full_q, aw_full_d;
  logic        wready_q,  wready_d,  w_full_q,  w_full_d;
  logic [11:0] awaddr_q,  awaddr_d;
  logic [31:0] wdata_q,   wdata_d;
  logic [3:0]  wstrb_q,   wstrb_d;
  logic        bvalid_q,  bvalid_d;
  logic [1:0]  bresp_q,   bresp_d;
  logic        arready_q, arready_d, rvalid_q, rvalid_d;
  logic [31:0] rdata_q,   rdata_d;
  logic [1:0]  rresp_q,   rresp_d;
  logic        aw_take, w_take, do_write, ar_take;
  logic [32:0] wr_pick, rd_pick;
  logic [31:0] merged;

  assign aw_take  = AWVALID_I && awready_q;
  assign w_take   = WVALID_I && wready_q;
  assign ar_take  = ARVALID_I && arready_q;
  assign do_write = aw_full_q && w_full_q && !bvalid_q;
  assign wr_pick  = reg_pick(awaddr_q, mr1_w, mr2_w, mr5_w, tim_w, stat_w);
  assign rd_pick  = reg_pick(ARADDR_I, mr1_w, mr2_w, mr5_w, tim_w, stat_w);
  assign merged   = odpd_pkg::apply_strb(wr_pick[31:0], wdata_q, wstrb_q);

  always_comb begin
    aw_full_d = aw_full_q;
    w_full_d  = w_full_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (aw_take) begin
      aw_full_d = 1'b1;
      awaddr_d  = AWADDR_I;
    end
    if (w_take) begin
      w_full_d = 1'b1;
      wdata_d  = WDATA_I;
      wstrb_d  = WSTRB_I;
    end
    if (bvalid_q && BREADY_I) begin
      bvalid_d = 1'b0;
    end
    if (do_write) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = wr_pick[32] ? odpd_pkg::RESP_OKAY : odpd_pkg::RESP_SLVERR;
    end
    // one write at a time: ready stays low until the response is gone
    awready_d = !aw_full_d && !bvalid_d;
    wready_d  = !w_full_d && !bvalid_d;
  end

  always_comb begin
    dll_en_d   = dll_en_q;
    rtt_nom_d  = rtt_nom_q;
    rtt_wr_d   = rtt_wr_q;
    buf_dis_d  = buf_dis_q;
    rtt_park_d = rtt_park_q;
    wl_d       = wl_q;
    if (do_write) begin
      case (awaddr_q)
        odpd_pkg::ADDR_MR1: begin
          dll_en_d  = merged[odpd_pkg::DLL_EN_BIT];
          rtt_nom_d = merged[odpd_pkg::NOM_LSB +: 3];
        end
        odpd_pkg::ADDR_MR2: begin
          rtt_wr_d = merged[odpd_pkg::WR_LSB +: 3];
        end
        odpd_pkg::ADDR_MR5: begin
          buf_dis_d  = merged[odpd_pkg::BUF_DIS_BIT];
          rtt_park_d = merged[odpd_pkg::PARK_LSB +: 3];
        end
        odpd_pkg::ADDR_TIMING: begin
          wl_d = merged[odpd_pkg::WL_LSB +: 5];
        end
        default: begin
          wl_d = wl_q;
        end
      endcase
    end
  end

  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (rvalid_q && RREADY_I) begin
      rvalid_d = 1'b0;
    end
    if (ar_take) begin
      rvalid_d = 1'b1;
      rdata_d  = rd_pick[31:0];
      rresp_d  = rd_pick[32] ? odpd_pkg::RESP_OKAY : odpd_pkg::RESP_SLVERR;
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      awready_q  <= 1'b0;
      wready_q   <= 1'b0;
      aw_full_q  <= 1'b0;
      w_full_q   <= 1'b0;
      awaddr_q   <= 12'h000;
      wdata_q    <= 32'h0;
      wstrb_q    <= 4'h0;
      bvalid_q   <= 1'b0;
      bresp_q    <= odpd_pkg::RESP_OKAY;
      arready_q  <= 1'b0;
      rvalid_q   <= 1'b0;
      rdata_q    <= 32'h0;
      rresp_q    <= odpd_pkg::RESP_OKAY;
      dll_en_q   <= odpd_pkg::DLL_EN_RST;
      rtt_nom_q  <= odpd_pkg::RTT_RST;
      rtt_wr_q   <= odpd_pkg::RTT_RST;
      buf_dis_q  <= 1'b0;
      rtt_park_q <= odpd_pkg::RTT_RST;
      wl_q       <= odpd_pkg::WL_RST;
    end else if (CE_I) begin
      awready_q  <= awready_d;
      wready_q   <= wready_d;
      aw_full_q  <= aw_full_d;
      w_full_q   <= w_full_d;
      awaddr_q   <= awaddr_d;
      wdata_q    <= wdata_d;
      wstrb_q    <= wstrb_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
      arready_q  <= arready_d;
      rvalid_q   <= rvalid_d;
      rdata_q    <= rdata_d;
      rresp_q    <= rresp_d;
      dll_en_q   <= dll_en_d;
      rtt_nom_q  <= rtt_nom_d;
      rtt_wr_q   <= rtt_wr_d;
      buf_dis_q  <= buf_dis_d;
      rtt_park_q <= rtt_park_d;
      wl_q       <= wl_d;
    end
  end

  assign AWREADY_O = awready_q;
  assign WREADY_O  = wready_q;
  assign BVALID_O  = bvalid_q;
  assign BRESP_O   = bresp_q;
  assign ARREADY_O = arready_q;
  assign RVALID_O  = rvalid_q;
  assign RDATA_O   = rdata_q;
  assign RRESP_O   = rresp_q;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);

  sequence s_async_high;
    CE_I && async_mode && odt_s && !pd_block && !async_nom;
  endsequence
  sequence s_async_low;
    CE_I && async_mode && !odt_s && async_nom;
  endsequence

  property p_dll_sel;
    CE_I && !dll_en_q && !pd_block && (async_nom != sync_nom) |=> nom_on_q == $past(async_nom);
  endproperty
  a_dll_sel: assert property (p_dll_sel) else $error("async timing not selected");

  property p_turn_on;
    s_async_high ##1 CE_I [*4] |-> ##0 (RTT_NOM_ON_O || !odt_s || pd_block || !async_mode);
  endproperty
  a_turn_on: assert property (p_turn_on) else $error("nominal not reached");

  property p_turn_off;
    s_async_low ##1 CE_I [*4] |-> ##0 (!RTT_NOM_ON_O || odt_s || !async_mode);
  endproperty
  a_turn_off: assert property (p_turn_off) else $error("park not reached");

  property p_pd_block;
    CE_I && pd_block |=> !RTT_NOM_ON_O;
  endproperty
  a_pd_block: assert property (p_pd_block) else $error("nominal during power-down");

  property p_flush;
    CE_I && pd_block |=> odt_pipe_q == '0;
  endproperty
  a_flush: assert property (p_flush) else $error("samples kept at entry");

  property p_nom_code;
    CE_I && nom_apply |=> RTT_CODE_O == $past(rtt_nom_q);
  endproperty
  a_nom_code: assert property (p_nom_code) else $error("wrong nominal code");

  property p_park_code;
    CE_I && !nom_apply |=> RTT_CODE_O == $past(rtt_park_q) && !RTT_NOM_ON_O;
  endproperty
  a_park_code: assert property (p_park_code) else $error("wrong park code");

  property p_sample;
    CE_I && !pd_block |=> odt_pipe_q[0] == $past(odt_s);
  endproperty
  a_sample: assert property (p_sample) else $error("odt sample lost");

  property p_dyn_flag;
    CE_I && ar_take && (ARADDR_I == odpd_pkg::ADDR_STATUS) && !dll_en_q &&
      (rtt_wr_q != 3'h0) |=> RDATA_O[6];
  endproperty
  a_dyn_flag: assert property (p_dyn_flag) else $error("write termination not flagged");

  property p_rd_answer;
    CE_I && ar_take |=> RVALID_O && !ARREADY_O;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
endmodule

// ===== hdl/odpd_pkg.sv
// constants, types and helpers shared by the termination control block
package odpd_pkg;

  // ---------------------------------------------------------------------------
  // clock and async turn windows
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 50;
  localparam int ASYNC_ON_MIN_NS    = 1;
  localparam int ASYNC_ON_MAX_NS    = 9;
  localparam int ASYNC_OFF_MIN_NS   = 1;
  localparam int ASYNC_OFF_MAX_NS   = 9;
  // least times round up, longest round down, never below one cycle
  localparam int ON_MIN_RAW  = (ASYNC_ON_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ON_MAX_RAW  = ASYNC_ON_MAX_NS / CLK_PERIOD_NS;
  localparam int OFF_MIN_RAW = (ASYNC_OFF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OFF_MAX_RAW = ASYNC_OFF_MAX_NS / CLK_PERIOD_NS;
  localparam logic [3:0] ON_MIN_CYC  = 4'((ON_MIN_RAW < 1) ? 1 : ON_MIN_RAW);
  localparam logic [3:0] ON_MAX_CYC  = 4'((ON_MAX_RAW < 1) ? 1 : ON_MAX_RAW);
  localparam logic [3:0] OFF_MIN_CYC = 4'((OFF_MIN_RAW < 1) ? 1 : OFF_MIN_RAW);
  localparam logic [3:0] OFF_MAX_CYC = 4'((OFF_MAX_RAW < 1) ? 1 : OFF_MAX_RAW);

  // ---------------------------------------------------------------------------
  // register map and fields
  // ---------------------------------------------------------------------------
  localparam logic [11:0] ADDR_MR1    = 12'h000;
  localparam logic [11:0] ADDR_MR2    = 12'h004;
  localparam logic [11:0] ADDR_MR5    = 12'h008;
  localparam logic [11:0] ADDR_TIMING = 12'h00C;
  localparam logic [11:0] ADDR_STATUS = 12'h010;
  localparam int DLL_EN_BIT  = 0;
  localparam int NOM_LSB     = 8;
  localparam int WR_LSB      = 9;
  localparam int BUF_DIS_BIT = 5;
  localparam int PARK_LSB    = 6;
  localparam int WL_LSB      = 0;
  localparam logic       DLL_EN_RST  = 1'b1;
  localparam logic [2:0] RTT_RST     = 3'h0;
  localparam logic [4:0] WL_RST      = 5'h09;
  localparam int PIPE_DEPTH = 32;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    TS_PARK    = 4'b0001,
    TS_TO_NOM  = 4'b0010,
    TS_NOM     = 4'b0100,
    TS_TO_PARK = 4'b1000
  } odpd_term_t;

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] apply_strb(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [4:0] lat_index(input logic [4:0] wl);
    return (wl < 5'h02) ? 5'h00 : 5'(wl - 5'h02);
  endfunction

endpackage

// ===== hdl/odpd_sync2.sv
// two-flop synchroniser for pins entering the command clock domain
`timescale 1ns/10ps
module odpd_sync2 #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // only the second stage reads the first
  always_comb begin
    meta_d = d_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (ce_i) begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q_o = sync_q;
endmodule

// ===== hdl/odpd_turn_timer.sv
// async termination turn-on / turn-off sequencer
`timescale 1ns/10ps
module odpd_turn_timer (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic req_i,
  output logic      nom_o,
  output logic      busy_o
);
  odpd_pkg::odpd_term_t st_q;
  odpd_pkg::odpd_term_t st_d;
  logic [3:0]           cnt_q;
  logic [3:0]           cnt_d;

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    case (st_q)
      odpd_pkg::TS_PARK: begin
        if (req_i) begin
          st_d  = odpd_pkg::TS_TO_NOM;
          cnt_d = 4'h1;
        end
      end
      odpd_pkg::TS_TO_NOM: begin
        if (!req_i) begin
          st_d  = odpd_pkg::TS_PARK;
          cnt_d = 4'h0;
        end else if (cnt_q >= odpd_pkg::ON_MAX_CYC) begin
          st_d  = odpd_pkg::TS_NOM;
          cnt_d = 4'h0;
        end else begin
          cnt_d = 4'(cnt_q + 4'h1);
        end
      end
      odpd_pkg::TS_NOM: begin
        if (!req_i) begin
          st_d  = odpd_pkg::TS_TO_PARK;
          cnt_d = 4'h1;
        end
      end
      odpd_pkg::TS_TO_PARK: begin
        if (req_i) begin
          st_d  = odpd_pkg::TS_NOM;
          cnt_d = 4'h0;
        end else if (cnt_q >= odpd_pkg::OFF_MAX_CYC) begin
          st_d  = odpd_pkg::TS_PARK;
          cnt_d = 4'h0;
        end else begin
          cnt_d = 4'(cnt_q + 4'h1);
        end
      end
      default: begin
        st_d  = odpd_pkg::TS_PARK;
        cnt_d = 4'h0;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q  <= odpd_pkg::TS_PARK;
      cnt_q <= 4'h0;
    end else if (ce_i) begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // park is left at the least time, nominal held until the off least time
  assign nom_o  = (st_q == odpd_pkg::TS_NOM) ||
                  ((st_q == odpd_pkg::TS_TO_NOM) && (cnt_q >= odpd_pkg::ON_MIN_CYC)) ||
                  ((st_q == odpd_pkg::TS_TO_PARK) && (cnt_q < odpd_pkg::OFF_MIN_CYC));
  assign busy_o = (st_q == odpd_pkg::TS_TO_NOM) || (st_q == odpd_pkg::TS_TO_PARK);
endmodule

// ===== tb/odpd_host_model.sv
// host controller model driving the termination and clock-enable pins
`timescale 1ns/10ps
module odpd_host_model #(
  parameter int DIS_CYC = 4,
  parameter int XP_CYC  = 3
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic odt_lvl_i,
  input  wire logic cke_lvl_i,
  input  wire logic float_i,
  output logic      odt_o,
  output logic      cke_o
);
  // ----------
  // pin drive
  // ----------
  int pd_n;
  int xp_n;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      odt_o <= 1'h0;
      cke_o <= 1'h1;
      pd_n  <= 0;
      xp_n  <= 0;
    end else begin
      cke_o <= cke_lvl_i;
      pd_n  <= cke_lvl_i ? 0 : pd_n + 1;
      xp_n  <= (cke_lvl_i && !cke_o) ? XP_CYC : ((xp_n > 0) ? xp_n - 1 : 0);
      if (cke_lvl_i && (!cke_o || xp_n > 0)) begin
        odt_o <= 1'h0;
      end else if (!cke_lvl_i && float_i && pd_n >= DIS_CYC) begin
        // no pull on this pin, so a released line shows a toggling pattern
        odt_o <= ~odt_o;
      end else if (!cke_lvl_i) begin
        odt_o <= odt_o;
      end else begin
        odt_o <= odt_lvl_i;
      end
    end
  end
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the termination control block
`timescale 1ns/10ps
module tb_top;
  // ----------
  // signals and instances
  // ----------
  logic        CLOCK_I, RST_I, ODT_I, CKE_I, RTT_NOM_ON_O, POWER_DOWN_O;
  logic [2:0]  RTT_CODE_O;
  logic [11:0] AWADDR_I, ARADDR_I;
  logic        AWVALID_I, AWREADY_O, WVALID_I, WREADY_O, BVALID_O, BREADY_I;
  logic        ARVALID_I, ARREADY_O, RVALID_O, RREADY_I;
  logic [31:0] WDATA_I, RDATA_O, d;
  logic [1:0]  BRESP_O, RRESP_O, r;
  logic        odt_lvl, cke_lvl, flt, ce;
  int          bad_count, cmp_count, n;

  odpd_top odpd_top_i (.CLOCK_I, .RST_I, .CE_I(ce), .ODT_I, .CKE_I, .RTT_CODE_O,
    .RTT_NOM_ON_O, .POWER_DOWN_O, .AWADDR_I, .AWVALID_I, .AWREADY_O, .WDATA_I,
    .WSTRB_I(4'hF), .WVALID_I, .WREADY_O, .BRESP_O, .BVALID_O, .BREADY_I, .ARADDR_I,
    .ARVALID_I, .ARREADY_O, .RDATA_O, .RRESP_O, .RVALID_O, .RREADY_I);
  odpd_host_model odpd_host_model_i (.clk_i(CLOCK_I), .rst_i(RST_I), .odt_lvl_i(odt_lvl),
    .cke_lvl_i(cke_lvl), .float_i(flt), .odt_o(ODT_I), .cke_o(CKE_I));

  initial begin
    CLOCK_I = 1'h0;
    forever #25 CLOCK_I = ~CLOCK_I;
  end

  // ----------
  // tasks
  // ----------
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic hang();
    bad_count++;
    $display("ERROR %0t wait ran out", $time);
    close_out();
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] v);
    int k;
    AWADDR_I  <= a;
    WDATA_I   <= v;
    AWVALID_I <= 1'h1;
    WVALID_I  <= 1'h1;
    BREADY_I  <= 1'h1;
    for (k = 0; k < 40; k++) begin
      @(posedge CLOCK_I);
      if (AWVALID_I && AWREADY_O === 1'h1) AWVALID_I <= 1'h0;
      if (WVALID_I && WREADY_O === 1'h1) WVALID_I <= 1'h0;
      if (BVALID_O === 1'h1) break;
    end
    if (k == 40) hang();
    r = BRESP_O;
    BREADY_I <= 1'h0;
    @(posedge CLOCK_I);
  endtask

  task automatic axi_rd(input logic [11:0] a);
    int k;
    ARADDR_I  <= a;
    ARVALID_I <= 1'h1;
    RREADY_I  <= 1'h1;
    for (k = 0; k < 40; k++) begin
      @(posedge CLOCK_I);
      if (ARVALID_I && ARREADY_O === 1'h1) ARVALID_I <= 1'h0;
      if (RVALID_O === 1'h1) break;
    end
    if (k == 40) hang();
    d = RDATA_O;
    r = RRESP_O;
    RREADY_I <= 1'h0;
    @(posedge CLOCK_I);
  endtask

  // pd selects the power-down flag, otherwise the nominal flag; n counts edges
  task automatic wait_for(input logic pd, input logic want, input int lim);
    n = 0;
    while (n < lim && (pd ? POWER_DOWN_O : RTT_NOM_ON_O) !== want) begin
      @(posedge CLOCK_I);
      n++;
    end
    if ((pd ? POWER_DOWN_O : RTT_NOM_ON_O) !== want) hang();
  endtask

  // ----------
  // main sequence
  // ----------
  initial begin
    RST_I     = 1'h1;
    AWADDR_I  = 12'h000;
    ARADDR_I  = 12'h000;
    WDATA_I   = 32'h0;
    AWVALID_I = 1'h0;
    WVALID_I  = 1'h0;
    BREADY_I  = 1'h0;
    ARVALID_I = 1'h0;
    RREADY_I  = 1'h0;
    odt_lvl   = 1'h0;
    cke_lvl   = 1'h1;
    flt       = 1'h0;
    ce        = 1'h1;
    bad_count = 0;
    cmp_count = 0;
    repeat (8) @(posedge CLOCK_I);
    RST_I <= 1'h0;
    repeat (2) @(posedge CLOCK_I);
    axi_rd(odpd_pkg::ADDR_MR1);
    check(d, 32'h0000_0001);
    axi_rd(odpd_pkg::ADDR_TIMING);
    check(d, 32'h0000_0009);
    axi_rd(12'h0FC);
    check(d, 32'h0);
    check(32'(r), 32'(odpd_pkg::RESP_SLVERR));
    axi_wr(12'h0FC, 32'hFFFF_FFFF);
    check(32'(r), 32'(odpd_pkg::RESP_SLVERR));
    // dll off, nominal 5, write termination 1, park 2
    axi_wr(odpd_pkg::ADDR_MR1, 32'h0000_0500);
    axi_wr(odpd_pkg::ADDR_MR2, 32'h0000_0200);
    axi_wr(odpd_pkg::ADDR_MR5, 32'h0000_0080);
    repeat (4) @(posedge CLOCK_I);
    check(32'(RTT_CODE_O), 32'h2);
    axi_rd(odpd_pkg::ADDR_STATUS);
    check(32'(d[6:5]), 32'h3);
    odt_lvl <= 1'h1;
    wait_for(1'h0, 1'h1, 20);
    check(32'(n <= 8), 32'h1);
    check(32'(RTT_CODE_O), 32'h5);
    odt_lvl <= 1'h0;
    wait_for(1'h0, 1'h0, 20);
    check(32'(n <= 8), 32'h1);
    check(32'(RTT_CODE_O), 32'h2);
    // power-down with the input buffer switched off, pin held then released
    axi_wr(odpd_pkg::ADDR_MR2, 32'h0);
    axi_wr(odpd_pkg::ADDR_MR5, 32'h0000_00A0);
    odt_lvl <= 1'h1;
    wait_for(1'h0, 1'h1, 20);
    cke_lvl <= 1'h0;
    flt     <= 1'h1;
    wait_for(1'h1, 1'h1, 20);
    wait_for(1'h0, 1'h0, 4);
    repeat (12) @(posedge CLOCK_I);
    check(32'(RTT_NOM_ON_O), 32'h0);
    check(32'(RTT_CODE_O), 32'h2);
    flt     <= 1'h0;
    odt_lvl <= 1'h1;
    cke_lvl <= 1'h1;
    wait_for(1'h1, 1'h0, 20);
    check(32'(ODT_I), 32'h0);
    check(32'(RTT_NOM_ON_O), 32'h0);
    // without buffer deactivation power-down leaves nominal alone
    axi_wr(odpd_pkg::ADDR_MR5, 32'h0000_0080);
    odt_lvl <= 1'h1;
    wait_for(1'h0, 1'h1, 20);
    cke_lvl <= 1'h0;
    wait_for(1'h1, 1'h1, 20);
    repeat (4) @(posedge CLOCK_I);
    check(32'(RTT_NOM_ON_O), 32'h1);
    cke_lvl <= 1'h1;
    odt_lvl <= 1'h0;
    wait_for(1'h0, 1'h0, 20);
    wait_for(1'h1, 1'h0, 20);
    // dll on: latency path replaces the direct one
    axi_wr(odpd_pkg::ADDR_MR1, 32'h0000_0501);
    repeat (6) @(posedge CLOCK_I);
    odt_lvl <= 1'h1;
    wait_for(1'h0, 1'h1, 40);
    check(32'(n > 8), 32'h1);
    axi_rd(odpd_pkg::ADDR_STATUS);
    check(32'(d[5]), 32'h0);
    // clock enable low freezes the applied termination against a pin change
    ce      <= 1'h0;
    odt_lvl <= 1'h0;
    repeat (12) @(posedge CLOCK_I);
    check(32'(RTT_NOM_ON_O), 32'h1);
    check(32'(RTT_CODE_O), 32'h5);
    ce      <= 1'h1;
    wait_for(1'h0, 1'h0, 40);
    check(32'(RTT_CODE_O), 32'h2);
    close_out();
  end
endmodule
